/* File: rtl/dcs_pkg.sv */
// Package with the command word layout, status layout and link frame types.
package dcs_pkg;

	// Single-register write function code and the register it targets.
	localparam logic [7:0]  FUNC_WRITE_SINGLE = 8'h06;
	localparam logic [15:0] CMD_REG_NUMBER    = 16'h0001;
	localparam logic [15:0] CMD_REG_ADDR      = CMD_REG_NUMBER - 16'h0001;
	localparam logic [15:0] CMD_RESET_VALUE   = 16'h0000;
	localparam logic [15:0] STATE_ZERO        = 16'h0000;

	// Command word bit positions.
	localparam int CMD_PRESET_LSB = 0;
	localparam int CMD_PRESET_MSB = 1;
	localparam int CMD_DC_RAMP    = 2;
	localparam int CMD_NO_COAST   = 3;
	localparam int CMD_NO_QSTOP   = 4;
	localparam int CMD_USE_RAMP   = 5;
	localparam int CMD_START      = 6;
	localparam int CMD_RESET      = 7;
	localparam int CMD_JOG        = 8;
	localparam int CMD_RAMP2      = 9;
	localparam int CMD_VALID      = 10;
	localparam int CMD_RELAY1     = 11;
	localparam int CMD_RELAY2     = 12;
	localparam int CMD_SETUP_LSB  = 13;
	localparam int CMD_SETUP_MSB  = 14;
	localparam int CMD_REVERSE    = 15;

	// Ways to merge a bus bit with its digital input.
	localparam logic [1:0] SEL_DIGITAL = 2'h0;
	localparam logic [1:0] SEL_BUS     = 2'h1;
	localparam logic [1:0] SEL_AND     = 2'h2;
	localparam logic [1:0] SEL_OR      = 2'h3;

	// One single-register write frame, CRC already checked outside.
	typedef struct packed {
		logic [7:0]  node;
		logic [7:0]  func;
		logic [15:0] addr;
		logic [15:0] data;
	} dcs_frame_s;

	// Drive conditions that feed the state word, bit 15 first.
	typedef struct packed {
		logic timer_over;
		logic torque_over;
		logic volt_over;
		logic auto_restart;
		logic running;
		logic freq_ok;
		logic bus_ctrl;
		logic speed_eq;
		logic warning;
		logic triplock;
		logic error_no_trip;
		logic trip;
		logic enable;
		logic drive_ready;
		logic ctrl_ready;
	} dcs_cond_s;

	// Digital input counterparts of the mergeable bus bits.
	typedef struct packed {
		logic [1:0] preset;
		logic       no_coast;
		logic       start;
		logic [1:0] setup;
		logic       reverse;
	} dcs_din_s;

	// Merge selections for the mergeable bits.
	typedef struct packed {
		logic [1:0] preset;
		logic [1:0] coast;
		logic [1:0] start;
		logic [1:0] setup;
		logic [1:0] reverse;
	} dcs_sel_s;

endpackage

/* File: rtl/dcs_cmd_status.sv */
// Command word interpreter and state word builder for the drive fieldbus.
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Function 06 writes, address is number minus one.
// - Echo query only after word taken over.
// - Bits 01:00 pick one of four presets.
// - Bit 02 low brakes with DC.
// - Bit 03 low shuts output stage off.
// - Bit 04 low makes quick-stop ramp.
// - Bit 05 low freezes frequency, inputs adjust.
// - Frozen drive stops only by coast/brake.
// - Bit 06 low ramps down, high permits start.
// - Trip reset only on bit 07 rising.
// - Bit 08 high selects jog speed.
// - Bit 10 low discards whole command word.
// - Bit 11 drives relay one when selected.
// - Bit 12 drives relay two when selected.
// - Bits 14:13 pick set-up in multi mode.
// - Bit 15 reverses for bus-based sources only.
// - Merge bus bits with digital inputs.
// - Build sixteen-bit state word, bit 05 zero.
// - Bit 00 low on trip, else ready.
// - Lost link clears every state bit.
module dcs_cmd_status (
	input  wire logic                 mclk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 ce_in,
	input  wire logic [7:0]           node_addr_in,
	input  wire logic                 query_valid_in,
	input  wire dcs_pkg::dcs_frame_s  query_in,
	input  wire dcs_pkg::dcs_din_s    din_in,
	input  wire dcs_pkg::dcs_sel_s    sel_in,
	input  wire logic                 din_speed_up_in,
	input  wire logic                 din_slow_down_in,
	input  wire logic                 din_stop_in,
	input  wire logic                 relay1_sel_bus_in,
	input  wire logic                 relay2_sel_bus_in,
	input  wire logic                 multi_setup_in,
	input  wire dcs_pkg::dcs_cond_s   cond_in,
	input  wire logic                 link_lost_in,
	input  wire logic                 comm_fault_in,
	output logic                      resp_valid_out,
	output dcs_pkg::dcs_frame_s       resp_out,
	output logic [1:0]                preset_sel_out,
	output logic                      dc_brake_out,
	output logic                      coast_out,
	output logic                      quick_stop_out,
	output logic                      freeze_out,
	output logic                      freq_up_out,
	output logic                      freq_down_out,
	output logic                      ramp_stop_out,
	output logic                      trip_reset_out,
	output logic                      jog_out,
	output logic                      ramp2_sel_out,
	output logic                      relay1_out,
	output logic                      relay2_out,
	output logic [1:0]                setup_sel_out,
	output logic                      reverse_out,
	output logic [15:0]               drive_state_word_out
);

	//////////////////////////////////////////////////////////////////////////
	// Merge of one bus bit with its digital input.
	function automatic logic merge(input logic bus_bit, input logic din_bit,
		input logic [1:0] mode);
		logic r;
		r = din_bit;
		unique case (mode)
			dcs_pkg::SEL_DIGITAL: r = din_bit;
			dcs_pkg::SEL_BUS:     r = bus_bit;
			dcs_pkg::SEL_AND:     r = bus_bit & din_bit;
			dcs_pkg::SEL_OR:      r = bus_bit | din_bit;
		endcase
		return r;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Query decode.
	logic [15:0]         drive_command_word_q;
	logic [15:0]         drive_command_word_d;
	logic                reset_bit_prev_q;
	logic                echo_pend_q;
	dcs_pkg::dcs_frame_s echo_frame_q;
	logic                write_hit;
	logic                word_valid;

	assign write_hit = query_valid_in && (query_in.node == node_addr_in)
		&& (query_in.func == dcs_pkg::FUNC_WRITE_SINGLE)
		&& (query_in.addr == dcs_pkg::CMD_REG_ADDR);
	// invalid words leave the command untouched
	assign word_valid = query_in.data[dcs_pkg::CMD_VALID];
	assign drive_command_word_d = (write_hit && word_valid) ? query_in.data
		: drive_command_word_q;

	//////////////////////////////////////////////////////////////////////////
	// Control decode from the stored command word.
	logic [15:0] cw;
	logic        coast_run;
	logic        start_run;
	logic        frozen;
	logic        trip_rise;
	logic [1:0]  preset_d;
	logic [1:0]  setup_d;
	logic        reverse_d;

	assign cw = drive_command_word_q;
	assign coast_run = merge(cw[dcs_pkg::CMD_NO_COAST], din_in.no_coast, sel_in.coast);
	assign start_run = merge(cw[dcs_pkg::CMD_START], din_in.start, sel_in.start);
	assign preset_d[0] = merge(cw[dcs_pkg::CMD_PRESET_LSB], din_in.preset[0], sel_in.preset);
	assign preset_d[1] = merge(cw[dcs_pkg::CMD_PRESET_MSB], din_in.preset[1], sel_in.preset);
	// set-up select, merged and gated by multi mode
	assign setup_d[0] = multi_setup_in
		& merge(cw[dcs_pkg::CMD_SETUP_LSB], din_in.setup[0], sel_in.setup);
	assign setup_d[1] = multi_setup_in
		& merge(cw[dcs_pkg::CMD_SETUP_MSB], din_in.setup[1], sel_in.setup);
	// digital-only source ignores the bus bit
	assign reverse_d = merge(cw[dcs_pkg::CMD_REVERSE], din_in.reverse, sel_in.reverse);
	// freeze while bit 05 is low
	assign frozen = ~cw[dcs_pkg::CMD_USE_RAMP];
	assign trip_rise = cw[dcs_pkg::CMD_RESET] & ~reset_bit_prev_q;

	//////////////////////////////////////////////////////////////////////////
	// State word assembly.
	logic [15:0] state_d;
	logic        state_kill;

	assign state_kill = link_lost_in | comm_fault_in;
	// field placement, bit 05 reserved as zero
	assign state_d = state_kill ? dcs_pkg::STATE_ZERO : {cond_in.timer_over,
		cond_in.torque_over, cond_in.volt_over, cond_in.auto_restart, cond_in.running,
		cond_in.freq_ok, cond_in.bus_ctrl, cond_in.speed_eq, cond_in.warning,
		cond_in.triplock, 1'b0, cond_in.error_no_trip, cond_in.trip, cond_in.enable,
		cond_in.drive_ready, cond_in.ctrl_ready & ~cond_in.trip};

	//////////////////////////////////////////////////////////////////////////
	// Registers. The echo trails the command update by one cycle, so the
	// master never sees an answer before the new word has taken effect.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			drive_command_word_q <= dcs_pkg::CMD_RESET_VALUE;
			reset_bit_prev_q     <= 1'b0;
			echo_pend_q          <= 1'b0;
			echo_frame_q         <= '0;
			resp_valid_out       <= 1'b0;
			resp_out             <= '0;
		end else if (ce_in) begin
			drive_command_word_q <= drive_command_word_d;
			reset_bit_prev_q     <= cw[dcs_pkg::CMD_RESET];
			// echo held until the word is stored
			echo_pend_q          <= write_hit;
			if (write_hit) begin
				echo_frame_q <= query_in;
			end
			resp_valid_out <= echo_pend_q;
			if (echo_pend_q) begin
				resp_out <= echo_frame_q;
			end
		end
	end

	// Outputs are registered so downstream power logic sees no glitches.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			preset_sel_out       <= 2'h0;
			dc_brake_out         <= 1'b1;
			coast_out            <= 1'b1;
			quick_stop_out       <= 1'b0;
			freeze_out           <= 1'b0;
			freq_up_out          <= 1'b0;
			freq_down_out        <= 1'b0;
			ramp_stop_out        <= 1'b0;
			trip_reset_out       <= 1'b0;
			jog_out              <= 1'b0;
			ramp2_sel_out        <= 1'b0;
			relay1_out           <= 1'b0;
			relay2_out           <= 1'b0;
			setup_sel_out        <= 2'h0;
			reverse_out          <= 1'b0;
			drive_state_word_out <= 16'h0000;
		end else if (ce_in) begin
			preset_sel_out <= preset_d;
			// DC brake on bit 02 low
			dc_brake_out   <= ~cw[dcs_pkg::CMD_DC_RAMP];
			coast_out      <= ~coast_run;
			// quick stop on bit 04 low
			quick_stop_out <= ~cw[dcs_pkg::CMD_NO_QSTOP] & ~frozen;
			// ramp stop when start not permitted
			ramp_stop_out  <= ~start_run & ~frozen;
			freeze_out     <= frozen & ~din_stop_in;
			// only digital inputs move a frozen frequency
			freq_up_out    <= frozen & din_speed_up_in;
			freq_down_out  <= frozen & din_slow_down_in;
			trip_reset_out <= trip_rise;
			jog_out        <= cw[dcs_pkg::CMD_JOG];
			ramp2_sel_out  <= cw[dcs_pkg::CMD_RAMP2];
			// relay one when routed to the bus bit
			relay1_out     <= relay1_sel_bus_in & cw[dcs_pkg::CMD_RELAY1];
			// relay two when routed to the bus bit
			relay2_out     <= relay2_sel_bus_in & cw[dcs_pkg::CMD_RELAY2];
			setup_sel_out  <= setup_d;
			reverse_out    <= reverse_d;
			drive_state_word_out <= state_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_write_taken;
		ce_in && write_hit;
	endsequence

	sequence s_echo_out;
		resp_valid_out && (resp_out == $past(query_in, 2));
	endsequence

	chk_echo_after_store: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		s_write_taken ##1 (ce_in && !write_hit) |=> resp_valid_out
			&& (!resp_out.data[dcs_pkg::CMD_VALID] || drive_command_word_q == resp_out.data)
	) else $error("echo sent before the word was stored");

	chk_echo_content: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		s_write_taken ##1 ce_in |=> s_echo_out
	) else $error("echo does not match query");

	chk_no_spurious_echo: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		$rose(resp_valid_out) && $past(ce_in) && $past(ce_in, 2) |-> $past(write_hit, 2)
	) else $error("echo without matching write");

	chk_invalid_ignored: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		(ce_in && write_hit && !word_valid) |=> $stable(drive_command_word_q)
	) else $error("invalid command word applied");

	chk_valid_applied: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		(ce_in && write_hit && word_valid) |=> drive_command_word_q == $past(query_in.data)
	) else $error("valid command word lost");

	chk_reset_edge: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		trip_reset_out && $past(ce_in) |-> $past(cw[dcs_pkg::CMD_RESET])
			&& !$past(reset_bit_prev_q)
	) else $error("trip reset without rising edge");

	chk_reset_single: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		(ce_in && trip_reset_out) |=> !trip_reset_out
	) else $error("trip reset repeated on steady bit");

	chk_state_kill: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		(ce_in && state_kill) |=> drive_state_word_out == 16'h0000
	) else $error("state word not cleared on link loss");

	chk_ready_trip: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		(ce_in && cond_in.trip) |=> !drive_state_word_out[0]
	) else $error("control ready shown while tripped");

	chk_reserved_zero: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		!drive_state_word_out[5]
	) else $error("reserved state bit set");

	chk_freeze_stops: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		(ce_in && frozen) |=> !quick_stop_out && !ramp_stop_out
	) else $error("ramp stop accepted while frozen");

	chk_relay_gate: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		(ce_in && !relay1_sel_bus_in) |=> !relay1_out
	) else $error("relay one driven while not routed");

	chk_setup_gate: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		(ce_in && !multi_setup_in) |=> setup_sel_out == 2'h0
	) else $error("set-up changed outside multi mode");

	chk_coast_bus: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		(ce_in && sel_in.coast == dcs_pkg::SEL_BUS && !cw[dcs_pkg::CMD_NO_COAST])
		|=> coast_out
	) else $error("coast bit ignored");

endmodule

/* File: bench/dcs_master_model.sv */
// Remote bus master model that issues single-register writes and catches echoes.
`timescale 1ns/100ps
module dcs_master_model (
	input  wire logic                mclk_in,
	input  wire logic                resp_valid_in,
	input  wire dcs_pkg::dcs_frame_s resp_in,
	output logic                     query_valid_out,
	output dcs_pkg::dcs_frame_s      query_out
);
	dcs_pkg::dcs_frame_s echo_q;
	int                  lat_q;

	initial begin
		query_valid_out = 1'b0;
		query_out = '0;
	end

	//////////////////////////////////////////////////////////////////////////
	// address one below number, data bit 0 LSB.
	task automatic write_reg(input logic [7:0] node, input logic [7:0] func,
			input logic [15:0] num, input logic [15:0] data);
		@(posedge mclk_in);
		query_valid_out <= 1'b1;
		query_out <= {node, func, num - 16'h0001, data};
		@(posedge mclk_in);
		query_valid_out <= 1'b0;
		// Released lines show the inverse so a late sampler cannot match by luck.
		query_out <= ~query_out;
		lat_q = 0;
		echo_q = '0;
		for (int i = 1; i <= 4; i++) begin
			@(posedge mclk_in);
			#1;
			if (resp_valid_in === 1'b1 && lat_q == 0) begin
				lat_q = i;
				echo_q = resp_in;
			end
		end
	endtask
endmodule

/* File: bench/drive_control_status_words_test.sv */
// Self-checking bench for the command interpreter and state word builder.
`timescale 1ns/100ps
module drive_control_status_words_test;
	logic                mclk_in = 1'b0;
	logic                rst_n_in = 1'b0;
	logic                ce_in = 1'b1;
	logic [7:0]          node_addr_in = 8'h11;
	logic                din_speed_up_in = 1'b1;
	logic                din_slow_down_in = 1'b0;
	logic                din_stop_in = 1'b0;
	logic                relay1_sel_bus_in = 1'b1;
	logic                relay2_sel_bus_in = 1'b1;
	logic                multi_setup_in = 1'b1;
	logic                link_lost_in = 1'b0;
	logic                comm_fault_in = 1'b0;
	dcs_pkg::dcs_din_s   din_in = '0;
	dcs_pkg::dcs_sel_s   sel_in = {5{dcs_pkg::SEL_BUS}};
	dcs_pkg::dcs_cond_s  cond_in = '0;
	dcs_pkg::dcs_frame_s query_in, resp_out;
	logic                query_valid_in, resp_valid_out, dc_brake_out, coast_out;
	logic                quick_stop_out, freeze_out, freq_up_out, freq_down_out;
	logic                ramp_stop_out, trip_reset_out, jog_out, ramp2_sel_out;
	logic                relay1_out, relay2_out, reverse_out;
	logic [1:0]          preset_sel_out, setup_sel_out;
	logic [15:0]         drive_state_word_out;
	int                  n_errors = 0;
	int                  n_checks = 0;
	int                  n_trip = 0;
	int                  t0;
	logic [15:0]         tw[5] = '{16'h0480, 16'h0480, 16'h0080, 16'h0400, 16'h0080};
	logic [15:0]         ww[4] = '{16'hFD7F, 16'h0555, 16'hD62B, 16'h0400};
	logic [14:0]         cv[3] = '{15'h7FFF, 15'h7FF7, 15'h2A5D};
	wire  [14:0]         ctl = {reverse_out, setup_sel_out, relay2_out, relay1_out,
		ramp2_sel_out, jog_out, ramp_stop_out, freeze_out, freq_up_out,
		quick_stop_out, coast_out, dc_brake_out, preset_sel_out};

	always #2.5 mclk_in = ~mclk_in;

	dcs_cmd_status dut_u (.mclk_in, .rst_n_in, .ce_in, .node_addr_in, .query_valid_in,
		.query_in, .din_in, .sel_in, .din_speed_up_in, .din_slow_down_in, .din_stop_in,
		.relay1_sel_bus_in, .relay2_sel_bus_in, .multi_setup_in, .cond_in, .link_lost_in,
		.comm_fault_in, .resp_valid_out, .resp_out, .preset_sel_out, .dc_brake_out,
		.coast_out, .quick_stop_out, .freeze_out, .freq_up_out, .freq_down_out,
		.ramp_stop_out, .trip_reset_out, .jog_out, .ramp2_sel_out, .relay1_out,
		.relay2_out, .setup_sel_out, .reverse_out, .drive_state_word_out);

	dcs_master_model m_u (.mclk_in, .resp_valid_in(resp_valid_out), .resp_in(resp_out),
		.query_valid_out(query_valid_in), .query_out(query_in));

	// A trip pulse away from its echo is weighted so the count cannot hide it.
	always @(posedge mclk_in) begin
		if (trip_reset_out === 1'b1) begin
			n_trip <= n_trip + ((resp_valid_out === 1'b1) ? 1 : 16);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic send(input logic [7:0] n, input logic [7:0] f, input logic [15:0] num,
			input logic [15:0] d, input bit ok);
		m_u.write_reg(n, f, num, d);
		// exact echo one edge after the store.
		if (ok) begin
			chk(m_u.echo_q, {n, f, num - 16'h0001, d});
			chk(m_u.lat_q, 1);
		end else begin
			chk(m_u.lat_q, 0);
		end
	endtask

	task automatic wr(input logic [15:0] d);
		send(8'h11, dcs_pkg::FUNC_WRITE_SINGLE, dcs_pkg::CMD_REG_NUMBER, d, 1'b1);
	endtask

	function automatic logic [14:0] exp_ctl(input logic [15:0] w, input logic stop);
		logic frz;
		frz = ~w[5];
		return {w[15], w[14:13], w[12], w[11], w[9], w[8], ~w[6] & ~frz, frz & ~stop, frz,
			~w[4] & ~frz, ~w[3], ~w[2], w[1:0]};
	endfunction

	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#25000;
		n_errors++;
		results();
	end

	//////////////////////////////////////////////////////////////////////////
	initial begin
		logic m0;
		repeat (4) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		#1;
		chk({dc_brake_out, coast_out}, 2'b11);
		send(8'h12, dcs_pkg::FUNC_WRITE_SINGLE, 16'h0001, 16'h0400, 1'b0);
		send(8'h11, 8'h05, 16'h0001, 16'h0400, 1'b0);
		send(8'h11, dcs_pkg::FUNC_WRITE_SINGLE, 16'h0002, 16'h0400, 1'b0);
		@(posedge mclk_in);
		ce_in <= 1'b0;
		send(8'h11, dcs_pkg::FUNC_WRITE_SINGLE, 16'h0001, 16'h0400, 1'b0);
		@(posedge mclk_in);
		ce_in <= 1'b1;
		$display("test refusals done");
		foreach (ww[i]) begin
			wr(ww[i]);
			chk(ctl, exp_ctl(ww[i], 1'b0));
		end
		t0 = n_trip;
		wr(16'h03FF);
		chk(ctl, exp_ctl(16'h0400, 1'b0));
		@(posedge mclk_in);
		din_stop_in <= 1'b1;
		din_slow_down_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		#1;
		chk(ctl, exp_ctl(16'h0400, 1'b1));
		chk({freq_up_out, freq_down_out}, 2'b11);
		@(posedge mclk_in);
		din_stop_in <= 1'b0;
		din_slow_down_in <= 1'b0;
		$display("test command decode done");
		foreach (tw[i]) wr(tw[i]);
		chk(n_trip - t0, 1);
		$display("test trip reset done");
		@(posedge mclk_in);
		relay1_sel_bus_in <= 1'b0;
		multi_setup_in <= 1'b0;
		sel_in.reverse <= dcs_pkg::SEL_DIGITAL;
		for (int b = 0; b < 2; b++) begin
			wr({8'hFC, 4'h0, b[0], 3'h0});
			@(posedge mclk_in);
			din_in.no_coast <= ~b[0];
			for (int m = 0; m < 4; m++) begin
				@(posedge mclk_in);
				sel_in.coast <= m[1:0];
				repeat (3) @(posedge mclk_in);
				#1;
				m0 = (m == 0) ? ~b[0] : (m == 1) ? b[0] : (m == 2) ? 1'b0 : 1'b1;
				chk({coast_out, relay1_out, relay2_out, setup_sel_out, reverse_out},
					{~m0, 5'b01000});
			end
		end
		$display("test merge done");
		foreach (cv[j]) begin
			for (int i = 0; i < 4; i++) begin
				@(posedge mclk_in);
				cond_in <= cv[j];
				{link_lost_in, comm_fault_in} <= i[1:0];
				repeat (2) @(posedge mclk_in);
				#1;
				chk(drive_state_word_out, (i != 0) ? 16'h0000 :
					{cv[j][14:5], 1'b0, cv[j][4:1], cv[j][0] & ~cv[j][3]});
			end
		end
		$display("test state word done");
		results();
	end
endmodule
